// >>> design/seq_pkg.sv
// Constants and types shared by the stack compute sequencer.
package seq_pkg;
    localparam int          SLOT_COUNT     = 12;
    localparam int          STACK_DEPTH    = 16;
    localparam logic [3:0]  LAST_SLOT      = 4'hB;
    localparam logic [3:0]  OP_FETCH_LAST  = 4'h3;
    localparam logic [3:0]  OP_AND         = 4'h4;
    localparam logic [3:0]  OP_OR          = 4'h5;
    localparam logic [3:0]  OP_XOR         = 4'h6;
    localparam logic [3:0]  OP_INV         = 4'h7;
    localparam logic [3:0]  OP_PUSH0       = 4'h8;
    localparam logic [3:0]  OP_POP         = 4'h9;
    localparam logic [3:0]  OP_DELAY       = 4'hA;
    localparam logic [3:0]  OP_LOOP        = 4'hB;
    localparam logic [3:0]  OP_DRIVE1      = 4'hC;
    localparam logic [3:0]  OP_DRIVE3      = 4'hE;
    localparam logic [3:0]  OP_END         = 4'hF;
    localparam logic [1:0]  INIT_KEEP      = 2'h0;
    localparam logic [1:0]  INIT_LOW       = 2'h1;
    localparam logic [1:0]  INIT_HIGH      = 2'h2;
    localparam logic [1:0]  INIT_FLOAT     = 2'h3;
    localparam logic [5:0]  THRESH_MIN     = 6'h00;
    localparam logic [5:0]  THRESH_MAX     = 6'h3F;
    localparam logic [2:0]  CLKSEL_RESET   = 3'h0;
    localparam logic [15:0] STACK_RESET    = 16'h0000;
    localparam logic [3:0]  SLOT_RESET     = 4'h0;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [2:0]  LINES_RESET    = 3'h0;
    localparam logic [2:0]  OE_RESET       = 3'h0;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} seq_state_t;
endpackage

// >>> design/delay_timer.sv
// Delay counter that counts periods of a selected tick.
`timescale 1ns/1ps
module delay_timer
    import seq_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       start_i,
    input  wire logic       cancel_i,
    input  wire logic [7:0] count_i,
    input  wire logic [2:0] clk_sel_i,
    input  wire logic [7:0] tick_i,
    output logic            done_o
);
    logic [7:0] left_q;
    logic       busy_q;
    logic       tick;

    assign tick = tick_i[clk_sel_i];

    // A count of zero finishes at once; otherwise one tick retires one period.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            left_q <= COUNT_RESET;
            busy_q <= 1'b0;
        end else if (cancel_i) begin
            busy_q <= 1'b0;
        end else if (start_i) begin
            left_q <= count_i;
            busy_q <= 1'b1;
        end else if (busy_q && tick && left_q != COUNT_RESET) begin
            left_q <= left_q - 8'h01; // [RULE14]
        end else if (busy_q && left_q == COUNT_RESET) begin
            busy_q <= 1'b0;
        end
    end

    assign done_o = busy_q && (left_q == COUNT_RESET) && !start_i;

    a_delay_step: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE14]
        busy_q && tick && left_q != COUNT_RESET && !start_i && !cancel_i |=> left_q == $past(left_q) - 8'h01)
        else $error("delay count did not step");
endmodule

// >>> design/stack_compute_sequencer.sv
// One-bit stack sequencer run once on each state entry of the state sequencer.
// What this block does
// [RULE1] Each fetch picks routing-matrix bit on select 0, comparator result on 1.
// [RULE2] Comparator fetches present their 6-bit threshold code to the comparator.
// [RULE3] Fetches one and two select analog inputs one to four.
// [RULE4] Fetches three and four select analog inputs five to eight.
// [RULE5] Each line starts from keep, low, high or undriven setting.
// [RULE6] Initial line settings reload on every state change.
// [RULE7] Command list runs only on entry to a new state, then returns control.
// [RULE8] State sequencer holds its state while this block is busy.
// [RULE9] Sequencer reset or abort stops execution and returns control at once.
// [RULE10] Loop command with zero on top waits delay, then jumps to slot.
// [RULE11] Loop target counts slots from 0 to 11.
// [RULE12] Fetch opcodes push a bit, shift down, drop location 15.
// [RULE13] AND, OR, XOR merge top two, shift up, fill location 15 with zero.
// [RULE14] Delay is 0 to 255 periods of a selected tick, shared by both delays.
// [RULE15] End opcode returns control immediately.
// [RULE16] Running past slot twelve ends as if an end command ran.
`timescale 1ns/1ps
module stack_compute_sequencer
    import seq_pkg::*;
#(
    parameter int SLOTS = SLOT_COUNT
)(
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 state_entry_i,
    input  wire logic                 sequencer_reset_n_i,
    input  wire logic                 compute_abort_i,
    input  wire logic [4*SLOTS-1:0]   program_i,
    input  wire logic [3:0]           loop_target_i,
    input  wire logic [7:0]           delay_count_i,
    input  wire logic [2:0]           delay_clk_sel_i,
    input  wire logic [7:0]           delay_tick_i,
    input  wire logic [3:0]           fetch_source_i,
    input  wire logic [3:0]           matrix_bit_i,
    input  wire logic                 compute_comparator_i,
    input  wire logic [5:0]           thresh_a_i,
    input  wire logic [1:0]           pin_sel_a_i,
    input  wire logic [5:0]           thresh_b_i,
    input  wire logic [1:0]           pin_sel_b_i,
    input  wire logic [5:0]           line_init_i,
    output logic                      busy_o,
    output logic                      hold_state_o,
    output logic [5:0]                comparator_thresh_o,
    output logic [2:0]                comparator_pin_o,
    output logic                      comparator_enable_o,
    output logic [2:0]                drive_line_o,
    output logic [2:0]                drive_line_oe_o
);
    seq_state_t  state_q;
    logic [15:0] stack_q;
    logic [3:0]  slot_q;
    logic        stop;
    logic        entry_q;
    logic        entry_edge;
    logic [3:0]  op;
    logic        fetch_bit;
    logic        delay_start;
    logic        delay_done;
    logic [1:0]  fsel;

    assign stop       = !sequencer_reset_n_i || compute_abort_i;
    assign entry_edge = state_entry_i && !entry_q;
    assign op         = program_i[4*slot_q +: 4];
    assign fsel       = op[1:0];

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            entry_q <= 1'b0;
        end else begin
            entry_q <= state_entry_i;
        end
    end

    // Fetch source: matrix bit or the comparator result.
    always_comb begin
        fetch_bit = fetch_source_i[fsel] ? compute_comparator_i : matrix_bit_i[fsel]; // [RULE1]
    end

    // The comparator is steered to the input of the fetch in progress, registered, so the setting appears one clock after that fetch.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            comparator_thresh_o <= THRESH_MIN;
            comparator_pin_o    <= 3'h0;
            comparator_enable_o <= 1'b0;
        end else begin
            comparator_enable_o <= state_q == ST_RUN && op <= OP_FETCH_LAST && fetch_source_i[fsel];
            if (fsel[1]) begin
                comparator_thresh_o <= thresh_b_i; // [RULE2]
                comparator_pin_o    <= {1'b1, pin_sel_b_i}; // [RULE4]
            end else begin
                comparator_thresh_o <= thresh_a_i; // [RULE2]
                comparator_pin_o    <= {1'b0, pin_sel_a_i}; // [RULE3]
            end
        end
    end

    assign delay_start = state_q == ST_RUN && !stop &&
                         (op == OP_DELAY || (op == OP_LOOP && !stack_q[0]));

    delay_timer u_delay (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .start_i   (delay_start),
        .cancel_i  (stop),
        .count_i   (delay_count_i),
        .clk_sel_i (delay_clk_sel_i),
        .tick_i    (delay_tick_i),
        .done_o    (delay_done)
    );

    // Sequencing; stop overrides everything and returns control at once.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            slot_q  <= SLOT_RESET;
        end else if (stop) begin
            state_q <= ST_IDLE; // [RULE9]
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (entry_edge) begin
                        state_q <= ST_RUN; // [RULE7]
                        slot_q  <= SLOT_RESET;
                    end
                end
                ST_RUN: begin
                    if (op == OP_END) begin
                        state_q <= ST_IDLE; // [RULE15]
                    end else if (delay_start) begin
                        state_q <= ST_WAIT;
                    end else if (slot_q >= LAST_SLOT) begin
                        state_q <= ST_IDLE; // [RULE16]
                    end else begin
                        slot_q <= slot_q + 4'h1;
                    end
                end
                ST_WAIT: begin
                    if (delay_done) begin
                        if (op == OP_LOOP) begin
                            // Targets beyond the last slot are clamped to it.
                            state_q <= ST_RUN;
                            slot_q  <= (loop_target_i > LAST_SLOT) ? LAST_SLOT : loop_target_i; // [RULE10] [RULE11]
                        end else if (slot_q >= LAST_SLOT) begin
                            state_q <= ST_IDLE; // [RULE16]
                        end else begin
                            state_q <= ST_RUN;
                            slot_q  <= slot_q + 4'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Stack of sixteen single bits, location 0 is the top.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            stack_q <= STACK_RESET;
        end else if (state_q == ST_RUN && !stop) begin
            case (op)
                4'h0, 4'h1, 4'h2, 4'h3: stack_q <= {stack_q[14:0], fetch_bit}; // [RULE12]
                OP_AND: stack_q <= {1'b0, stack_q[15:2], stack_q[0] & stack_q[1]}; // [RULE13]
                OP_OR:  stack_q <= {1'b0, stack_q[15:2], stack_q[0] | stack_q[1]}; // [RULE13]
                OP_XOR: stack_q <= {1'b0, stack_q[15:2], stack_q[0] ^ stack_q[1]}; // [RULE13]
                OP_INV: stack_q <= {stack_q[15:1], ~stack_q[0]};
                OP_PUSH0: stack_q <= {stack_q[14:0], 1'b0};
                OP_POP: stack_q <= {1'b0, stack_q[15:1]};
                default: stack_q <= stack_q;
            endcase
        end
    end

    // Output lines: initial settings on each state entry, then drive commands.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_line
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    drive_line_o[g]    <= LINES_RESET[g];
                    drive_line_oe_o[g] <= OE_RESET[g];
                end else if (entry_edge && state_q == ST_IDLE) begin
                    case (line_init_i[2*g +: 2]) // [RULE5] [RULE6]
                        INIT_LOW: begin
                            drive_line_o[g]    <= 1'b0;
                            drive_line_oe_o[g] <= 1'b1;
                        end
                        INIT_HIGH: begin
                            drive_line_o[g]    <= 1'b1;
                            drive_line_oe_o[g] <= 1'b1;
                        end
                        INIT_FLOAT: begin
                            drive_line_oe_o[g] <= 1'b0;
                        end
                        default: begin
                            drive_line_o[g] <= drive_line_o[g];
                        end
                    endcase
                end else if (state_q == ST_RUN && !stop && op == OP_DRIVE1 + 4'(g)) begin
                    drive_line_o[g]    <= stack_q[0];
                    drive_line_oe_o[g] <= 1'b1;
                end
            end
        end
    endgenerate

    assign busy_o       = state_q != ST_IDLE;
    assign hold_state_o = busy_o || (entry_edge && !stop); // [RULE8]

    a_stop_returns: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE9]
        stop |=> state_q == ST_IDLE) else $error("stop did not return control");
    a_end_returns: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE15]
        state_q == ST_RUN && op == OP_END |=> !busy_o) else $error("end did not finish");
    a_entry_starts: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE7]
        state_q == ST_IDLE && entry_edge && !stop |=> state_q == ST_RUN && slot_q == 4'h0)
        else $error("entry did not start at slot 0");
    a_slot_bound: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE16] [RULE11]
        slot_q <= LAST_SLOT) else $error("slot beyond last");
    a_hold_busy: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE8]
        busy_o |-> hold_state_o) else $error("state not held while busy");
    // The hold must already stand in the entry cycle, or the state sequencer could slip a move in before the run.
    a_hold_entry: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE8]
        $rose(busy_o) |-> $past(hold_state_o)) else $error("state not held on entry");
    a_fetch_push: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE12]
        state_q == ST_RUN && !stop && op <= OP_FETCH_LAST |=> stack_q[15:1] == $past(stack_q[14:0])
        && stack_q[0] == $past(fetch_bit)) else $error("fetch push wrong");
    a_and_merge: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE13]
        state_q == ST_RUN && !stop && op == OP_AND |=> stack_q[0] == ($past(stack_q[0]) & $past(stack_q[1]))
        && !stack_q[15]) else $error("and merge wrong");
    a_loop_taken: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE10]
        state_q == ST_RUN && !stop && op == OP_LOOP && !stack_q[0] |=> state_q == ST_WAIT)
        else $error("loop did not wait");
    a_init_high: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE5] [RULE6]
        entry_edge && state_q == ST_IDLE && line_init_i[3:2] == INIT_HIGH
        |=> drive_line_o[1] && drive_line_oe_o[1])
        else $error("initial high not loaded");
    a_source_pick: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE1]
        fetch_source_i[fsel] |-> fetch_bit == compute_comparator_i) else $error("fetch source wrong");

    sequence s_loop_expires;
        state_q == ST_WAIT && op == OP_LOOP && delay_done && !stop;
    endsequence
    a_loop_jump: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE10] [RULE11]
        s_loop_expires ##0 loop_target_i <= LAST_SLOT |=> state_q == ST_RUN && slot_q == $past(loop_target_i))
        else $error("loop did not jump to target");
endmodule

// >>> test/state_machine_model.sv
// Behavioural state machine partner that steps to a new state on request.
`timescale 1ns/1ps
module state_machine_model (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic change_i,
    input  wire logic hold_state_i,
    output logic      state_entry_o
);
    logic pend_q;
    logic entry_q;
    assign state_entry_o = entry_q;
    // A requested change waits out the hold, so no transition lands while the sequencer owns control.
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pend_q  <= 1'b0;
            entry_q <= 1'b0;
        end else if (change_i) begin
            pend_q <= 1'b1;
        end else if (pend_q && !hold_state_i) begin
            entry_q <= !entry_q;
            pend_q  <= entry_q;
        end
    end
endmodule

// >>> test/test_stack_compute_sequencer.sv
// Self-checking bench for the stack compute sequencer beside its state machine partner.
`timescale 1ns/1ps
module test_stack_compute_sequencer;
    import seq_pkg::*;
    logic        clock_i, reset_i, change, seq_rst_n, abort, comp, busy, hold, entry, cmp_en, cmp_en_s;
    logic [47:0] prog;
    logic [3:0]  target, source, matrix;
    logic [7:0]  dcount, tick;
    logic [1:0]  psel_a, psel_b, tick_cnt;
    logic [5:0]  thr_a, thr_b, init, cmp_thr, cmp_thr_s;
    logic [2:0]  csel, cmp_pin, cmp_pin_s, lines, oe;
    int          errors, n_checks, cnt;

    state_machine_model sm_u (.clock_i(clock_i), .reset_i(reset_i), .change_i(change), .hold_state_i(hold),
        .state_entry_o(entry));
    stack_compute_sequencer dut_u (.clock_i(clock_i), .reset_i(reset_i), .state_entry_i(entry),
        .sequencer_reset_n_i(seq_rst_n), .compute_abort_i(abort), .program_i(prog), .loop_target_i(target),
        .delay_count_i(dcount), .delay_clk_sel_i(csel), .delay_tick_i(tick), .fetch_source_i(source),
        .matrix_bit_i(matrix), .compute_comparator_i(comp), .thresh_a_i(thr_a), .pin_sel_a_i(psel_a),
        .thresh_b_i(thr_b), .pin_sel_b_i(psel_b), .line_init_i(init), .busy_o(busy), .hold_state_o(hold),
        .comparator_thresh_o(cmp_thr), .comparator_pin_o(cmp_pin), .comparator_enable_o(cmp_en),
        .drive_line_o(lines), .drive_line_oe_o(oe));

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // Only delay clock choice 5 ticks, once in four cycles, so a wrong select stalls the loop delay.
    always @(posedge clock_i) begin
        if (reset_i) begin
            tick_cnt <= 2'h0;
            tick     <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 2'h1;
            tick     <= (tick_cnt == 2'h3) ? 8'h20 : 8'h00;
        end
    end

    task automatic complete_run();
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic start(input logic [47:0] p);
        int i;
        @(posedge clock_i);
        prog   <= p;
        change <= 1'b1;
        @(posedge clock_i);
        change <= 1'b0;
        for (i = 0; i < 20 && busy !== 1'b1; i++) begin
            @(posedge clock_i);
            #1;
        end
        if (busy !== 1'b1) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic finish();
        cnt = 0;
        while (busy === 1'b1 && cnt < 700) begin
            chk("hold_state", 8'h01, {7'h0, hold});
            if (cnt == 3) begin
                cmp_pin_s = cmp_pin;
                cmp_thr_s = cmp_thr;
                cmp_en_s  = cmp_en;
            end
            @(posedge clock_i);
            #1;
            cnt++;
        end
        if (busy !== 1'b0) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic sc_logic();
        @(posedge clock_i);
        source <= 4'hC;
        matrix <= 4'hF;
        init   <= 6'h15;
        start(48'hFFFE61D3C520);
        finish();
        chk("run_length", 8'h0A, cnt[7:0]);
        chk("lines", 8'h05, {5'h0, lines});
        chk("line_enables", 8'h07, {5'h0, oe});
    endtask

    task automatic sc_compare();
        int k;
        for (k = 0; k < 4; k++) begin
            @(posedge clock_i);
            source <= 4'hF;
            psel_a <= k[1:0];
            psel_b <= ~k[1:0];
            thr_a  <= {3{k[1:0]}};
            thr_b  <= ~{3{k[1:0]}};
            start(48'h000000000000);
            finish();
            chk("run_length", 8'h0C, cnt[7:0]);
            chk("pin_a", {6'h0, k[1:0]}, {5'h0, cmp_pin_s});
            chk("thresh_a", {2'h0, {3{k[1:0]}}}, {2'h0, cmp_thr_s});
            chk("cmp_enable", 8'h01, {7'h0, cmp_en_s});
            start(48'h222222222222);
            finish();
            chk("pin_b", {5'h0, 1'b1, ~k[1:0]}, {5'h0, cmp_pin_s});
            chk("thresh_b", {2'h0, ~{3{k[1:0]}}}, {2'h0, cmp_thr_s});
        end
    endtask

    task automatic sc_lines();
        @(posedge clock_i);
        init <= 6'h39;
        start(48'hFFFFFFFFFFFF);
        finish();
        chk("lines_init", 8'h02, {6'h0, lines[1:0]});
        chk("oe_init", 8'h03, {5'h0, oe});
        @(posedge clock_i);
        init <= 6'h00;
        start(48'hFFFFFFFFFFFF);
        finish();
        chk("lines_keep", 8'h02, {6'h0, lines[1:0]});
        chk("oe_keep", 8'h03, {6'h0, oe[1:0]});
        repeat (5) @(posedge clock_i);
        #1;
        chk("no_rerun", 8'h00, {7'h0, busy});
    endtask

    task automatic sc_stop();
        int s;
        for (s = 0; s < 2; s++) begin
            @(posedge clock_i);
            dcount <= 8'hFF;
            start(48'hAAAAAAAAAAAA);
            repeat (4) @(posedge clock_i);
            if (s == 0) abort <= 1'b1;
            else seq_rst_n <= 1'b0;
            @(posedge clock_i);
            #1;
            chk("stop_busy", 8'h00, {7'h0, busy});
            chk("stop_hold", 8'h00, {7'h0, hold});
            @(posedge clock_i);
            abort     <= 1'b0;
            seq_rst_n <= 1'b1;
        end
    endtask

    task automatic sc_loop();
        int s;
        for (s = 0; s < 2; s++) begin
            @(posedge clock_i);
            source <= 4'h0;
            matrix <= {3'h0, s[0]};
            target <= 4'hB;
            dcount <= 8'h08;
            csel   <= 3'h5;
            start(48'hF888888888B0);
            finish();
            if (s == 1) chk("loop_skip", 8'h0C, cnt[7:0]);
            else chk("loop_delay", 8'h01, {7'h0, cnt >= 33 && cnt <= 36});
        end
    endtask

    initial begin
        reset_i = 1'b1;
        change = 1'b0;
        seq_rst_n = 1'b1;
        abort = 1'b0;
        comp = 1'b0;
        prog = 48'hFFFFFFFFFFFF;
        {target, source, matrix, dcount, csel, psel_a, psel_b, thr_a, thr_b, init} = '0;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        sc_logic();
        sc_compare();
        sc_lines();
        sc_stop();
        sc_loop();
        complete_run();
    end
endmodule
